// >>> logic/epo_params.svh
`ifndef EPO_PARAMS_SVH
`define EPO_PARAMS_SVH

// Clock and time base
`define EPO_CLK_NS 50
`define EPO_TICK_NS 1000000
`define EPO_TICK_CYC (`EPO_TICK_NS / `EPO_CLK_NS)

// Sizes
`define EPO_SLOTS 4
`define EPO_USER_SLOTS 3
`define EPO_CHANS 9
`define EPO_STATUS_IN 16

// Port selection codes
`define EPO_SEL_NONE 4'h0
`define EPO_SEL_CAL_CHAN 4'h7

// Pulse width limits and defaults, in milliseconds
`define EPO_MAX_MS 32'h77359400
`define EPO_PULSER_MIN_MS 32'h00000014
`define EPO_CAL_MIN_MS 32'h0000000a
`define EPO_CAL_MAX_MS 32'h000003e8
`define EPO_CAL_DEF_MS 32'h00000032

// Energy quantum limits and default, in hundredths of a unit
`define EPO_Q_MIN 40'h0000000001
`define EPO_Q_MAX 40'h02540be400
`define EPO_Q_DEF 40'h00000000b4

// Inactive level of an unowned channel
`define EPO_IDLE_LEVEL 1'b0

`endif

// >>> logic/epo_pkg.sv
package epo_pkg;

  // Controller function kind
  typedef enum logic [1:0] {
    EPO_KIND_LEVEL = 2'b00,
    EPO_KIND_PULSER = 2'b01,
    EPO_KIND_CALIB = 2'b10
  } epo_kind_e;

  // Output waveform select
  typedef enum logic {
    EPO_WAVE_FULL = 1'b0,
    EPO_WAVE_KYZ = 1'b1
  } epo_wave_e;

  // Integration direction
  typedef enum logic [1:0] {
    EPO_INT_FORWARD = 2'b00,
    EPO_INT_REVERSE = 2'b01,
    EPO_INT_ABSOLUTE = 2'b10,
    EPO_INT_NET = 2'b11
  } epo_int_e;

  // One function slot configuration
  typedef struct packed {
    logic [3:0] port_sel;
    epo_kind_e kind;
    logic invert;
    logic state_change_logging_select;
    epo_wave_e output_waveform_select;
    epo_int_e int_mode;
    logic [31:0] width_ms;
    logic [39:0] energy_per_pulse_quantum;
  } epo_cfg_s;

endpackage : epo_pkg

// >>> logic/epo_slot_if.sv
`timescale 1ns/100ps
// Signals between the port router and one function engine
interface epo_slot_if;
  import epo_pkg::*;
  epo_cfg_s cfg; // Slot configuration
  logic level_in; // Boolean source
  logic trigger; // Instantaneous trigger
  logic signed [31:0] power; // Power sample
  logic power_valid; // Sample strobe
  logic ms_tick; // Millisecond enable
  logic drive; // Output level after polarity
  logic log_strobe; // State change event
  modport router (output cfg, output level_in, output trigger, output power,
    output power_valid, output ms_tick, input drive, input log_strobe);
  modport func (input cfg, input level_in, input trigger, input power,
    input power_valid, input ms_tick, output drive, output log_strobe);
endinterface : epo_slot_if

// >>> logic/epo_func.sv
`timescale 1ns/100ps
`include "epo_params.svh"
// One controller function: level/pulse, pulse converter or energy integrator
module epo_func (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Router side
  epo_slot_if.func sl
);
  import epo_pkg::*;

  logic pulse_on; // Full pulse running
  logic [31:0] remain; // Milliseconds left in pulse
  logic kyz; // Transition state
  logic level_d; // Previous Boolean input
  logic signed [47:0] acc; // Energy accumulator

  wire is_level = sl.cfg.kind == EPO_KIND_LEVEL;
  wire is_pulser = sl.cfg.kind == EPO_KIND_PULSER;
  wire is_calib = sl.cfg.kind == EPO_KIND_CALIB;
  wire [31:0] w_raw = sl.cfg.width_ms;
  // Width limits per kind; out-of-range settings are clamped, not rejected
  wire [31:0] w_lo = is_pulser ? `EPO_PULSER_MIN_MS : (is_calib ? `EPO_CAL_MIN_MS : 32'h0);
  wire [31:0] w_hi = is_calib ? `EPO_CAL_MAX_MS : `EPO_MAX_MS;
  wire [31:0] width = (w_raw < w_lo) ? w_lo : ((w_raw > w_hi) ? w_hi : w_raw);
  wire level_cont = is_level && (width == 32'h0);
  wire [39:0] q_raw = sl.cfg.energy_per_pulse_quantum;
  wire [39:0] q_cl = (q_raw < `EPO_Q_MIN) ? `EPO_Q_MIN :
    ((q_raw > `EPO_Q_MAX) ? `EPO_Q_MAX : q_raw);
  wire signed [47:0] quantum = {8'h00, q_cl};

  // Power contribution by integration direction
  wire signed [47:0] p_ext = {{16{sl.power[31]}}, sl.power};
  wire p_neg = sl.power[31];
  wire signed [47:0] p_fwd = p_neg ? 48'sh0 : p_ext;
  wire signed [47:0] p_rev = p_neg ? -p_ext : 48'sh0;
  wire signed [47:0] p_abs = p_neg ? -p_ext : p_ext;
  wire signed [47:0] contrib = (sl.cfg.int_mode == EPO_INT_FORWARD) ? p_fwd :
    (sl.cfg.int_mode == EPO_INT_REVERSE) ? p_rev :
    (sl.cfg.int_mode == EPO_INT_ABSOLUTE) ? p_abs : p_ext;
  wire signed [47:0] acc_sum = sl.power_valid ? acc + contrib : acc;
  wire cal_fire = is_calib && (acc_sum >= quantum);
  // Take off one quantum per cycle and carry the rest; a quantum reached during a running full pulse gives no pulse
  wire signed [47:0] next_acc = cal_fire ? acc_sum - quantum : acc_sum;

  // Event per function kind
  wire level_rise = sl.level_in && !level_d;
  wire evt = is_pulser ? sl.trigger : (is_calib ? cal_fire : level_rise);
  wire kyz_mode = !is_level && (sl.cfg.output_waveform_select == EPO_WAVE_KYZ);
  wire start = evt && !kyz_mode && !level_cont && !pulse_on;
  wire pulse_end = pulse_on && sl.ms_tick && (remain == 32'h1);
  wire raw = level_cont ? sl.level_in : (kyz_mode ? kyz : pulse_on);
  wire next_drive = raw ^ sl.cfg.invert;

  // Accumulator, moving while integrating and cleared to zero otherwise
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      acc <= 48'sh0;
    else if (is_calib)
      acc <= next_acc;
    else
      acc <= 48'sh0;
  end

  // Pulse timer; an event during a running pulse is dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulse_on <= 1'b0;
      remain <= 32'h0;
    end
    else if (start)
    begin
      pulse_on <= 1'b1;
      remain <= width;
    end
    else if (pulse_end)
      pulse_on <= 1'b0;
    else if (pulse_on && sl.ms_tick)
      remain <= remain - 32'h1;
  end

  // Transition toggle and input edge history
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      kyz <= 1'b0;
      level_d <= 1'b0;
    end
    else
    begin
      level_d <= sl.level_in;
      if (evt && kyz_mode)
        kyz <= !kyz;
    end
  end

  // Registered output and state change event
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sl.drive <= 1'b0;
      sl.log_strobe <= 1'b0;
    end
    else
    begin
      sl.drive <= next_drive;
      sl.log_strobe <= sl.cfg.state_change_logging_select && (next_drive != sl.drive);
    end
  end

endmodule : epo_func

// >>> logic/epo_router.sv
`timescale 1ns/100ps
`include "epo_params.svh"
// Behaviour
// - A port has at most one owning function
// - Unassigning or removing a function frees its port
// - Seven outputs plus energy and alarm LEDs
// - Eight status inputs, expansion continues from nine
// - Every output drives a level or a pulse
// - Level function follows input; zero width holds level
// - Polarity inverts or passes the output
// - Optional event on each output state change
// - Pulse converter turns triggers into pulses
// - Full pulse or KYZ toggle per event
// - Integrator emits one event per energy quantum
// - Integrator pulse width 10 ms to 1 s
// - Integrate forward, reverse, absolute or net
// - Channel seven owned by factory energy integrator
// - Alarm LED drivable like any channel
module epo_router #(
  parameter int TICK_CYCLES = `EPO_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Factory integrator
  input wire logic factory_calibration_integrator_keep,
  input wire logic signed [31:0] total_real_power_source,
  input wire logic total_real_power_valid,
  // User function slots
  input wire epo_pkg::epo_cfg_s [`EPO_USER_SLOTS-1:0] user_cfg,
  input wire logic [`EPO_USER_SLOTS-1:0] user_present,
  input wire logic [`EPO_USER_SLOTS-1:0] user_level_in,
  input wire logic [`EPO_USER_SLOTS-1:0] user_trigger,
  input wire logic signed [`EPO_USER_SLOTS-1:0][31:0] user_power,
  input wire logic [`EPO_USER_SLOTS-1:0] user_power_valid,
  // Status input pins
  input wire logic [`EPO_STATUS_IN-1:0] status_pin,
  // Output channels: bit 0 is channel one
  output logic [`EPO_CHANS-1:0] channel_out,
  // Ownership view
  output logic [`EPO_CHANS-1:0] channel_free,
  output logic [`EPO_SLOTS-1:0] slot_granted,
  // Event log
  output logic [`EPO_SLOTS-1:0] state_change_event,
  // Synchronised status inputs
  output logic [`EPO_STATUS_IN-1:0] status_in
);
  import epo_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

  // Named output channels
  wire relay_channel_one = channel_out[0];
  wire solid_state_channel_one = channel_out[3];
  wire calibration_solid_state_channel = channel_out[6];
  wire energy_pulse_led_channel = channel_out[7];
  wire alarm_led_channel = channel_out[8];

  logic [CW-1:0] tick_cnt; // Millisecond divider
  logic ms_tick; // One-cycle enable each millisecond
  logic [`EPO_STATUS_IN-1:0] status_meta; // First synchroniser stage
  logic [`EPO_CHANS-1:0] owner_valid; // Channel owned
  logic [1:0] owner_slot [`EPO_CHANS]; // Owning slot per channel
  logic [`EPO_SLOTS-1:0] present; // Slot exists
  logic [`EPO_SLOTS-1:0] slot_drive; // Each slot's output level
  logic [`EPO_SLOTS-1:0] slot_log; // Each slot's change event
  logic [3:0] slot_sel [`EPO_SLOTS]; // Port selection per slot
  epo_cfg_s factory_cfg; // Fixed factory integrator settings

  epo_slot_if slot_bus [`EPO_SLOTS] ();

  // Factory integrator on channel seven, pulse mode, absolute power
  assign factory_cfg.port_sel = `EPO_SEL_CAL_CHAN;
  assign factory_cfg.kind = EPO_KIND_CALIB;
  assign factory_cfg.invert = 1'b0;
  assign factory_cfg.state_change_logging_select = 1'b0;
  assign factory_cfg.output_waveform_select = EPO_WAVE_FULL;
  assign factory_cfg.int_mode = EPO_INT_ABSOLUTE;
  assign factory_cfg.width_ms = `EPO_CAL_DEF_MS;
  assign factory_cfg.energy_per_pulse_quantum = `EPO_Q_DEF;

  // Removing the factory slot releases channel seven
  assign present = {user_present, factory_calibration_integrator_keep};

  // Millisecond divider shared by every pulse timer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt <= '0;
    else if (tick_cnt == TICK_LAST)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  // Tick pulse registered to keep it glitch free
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ms_tick <= 1'b0;
    else
      ms_tick <= (tick_cnt == TICK_LAST);
  end

  // Status pins are asynchronous: two stages before use
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_meta <= '0;
      status_in <= '0;
    end
    else
    begin
      status_meta <= status_pin;
      status_in <= status_meta;
    end
  end

  // Slot wiring and one engine per slot
  generate
    for (genvar s = 0; s < `EPO_SLOTS; s++)
    begin : g_slot
      if (s == 0)
      begin : g_fac
        assign slot_bus[s].cfg = factory_cfg;
        assign slot_bus[s].level_in = 1'b0;
        assign slot_bus[s].trigger = 1'b0;
        assign slot_bus[s].power = total_real_power_source;
        assign slot_bus[s].power_valid = total_real_power_valid;
      end
      else
      begin : g_usr
        assign slot_bus[s].cfg = user_cfg[s-1];
        assign slot_bus[s].level_in = user_level_in[s-1];
        assign slot_bus[s].trigger = user_trigger[s-1];
        assign slot_bus[s].power = user_power[s-1];
        assign slot_bus[s].power_valid = user_power_valid[s-1];
      end
      assign slot_bus[s].ms_tick = ms_tick;
      assign slot_drive[s] = slot_bus[s].drive;
      assign slot_log[s] = slot_bus[s].log_strobe;
      // An absent slot selects nothing
      assign slot_sel[s] = present[s] ? slot_bus[s].cfg.port_sel : `EPO_SEL_NONE;

      epo_func u_func (
        .clk(clk),
        .reset_n(reset_n),
        .sl(slot_bus[s])
      );

      // Granted only while this slot really owns its selected channel
      wire sel_ok = (slot_sel[s] != `EPO_SEL_NONE) && (slot_sel[s] <= 4'(`EPO_CHANS));
      wire [3:0] sel_idx = slot_sel[s] - 4'h1;
      assign slot_granted[s] = sel_ok && owner_valid[sel_idx] &&
        (owner_slot[sel_idx] == 2'(s));
      // Events are only reported for a slot that drives a channel
      assign state_change_event[s] = slot_log[s] && slot_granted[s];
    end
  endgenerate

  // Ownership and output drive per channel
  generate
    for (genvar c = 0; c < `EPO_CHANS; c++)
    begin : g_chan
      logic [`EPO_SLOTS-1:0] claim;
      logic [1:0] first;
      for (genvar s = 0; s < `EPO_SLOTS; s++)
      begin : g_claim
        assign claim[s] = (slot_sel[s] == 4'(c + 1));
      end
      // Lowest numbered claimant wins a free channel
      assign first = claim[0] ? 2'd0 : (claim[1] ? 2'd1 : (claim[2] ? 2'd2 : 2'd3));
      // Owner keeps the channel while it still selects it
      wire keep = owner_valid[c] && claim[owner_slot[c]];
      wire next_valid = keep || (|claim);
      wire [1:0] next_owner = keep ? owner_slot[c] : first;

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          owner_valid[c] <= 1'b0;
          owner_slot[c] <= 2'd0;
        end
        else
        begin
          owner_valid[c] <= next_valid;
          owner_slot[c] <= next_owner;
        end
      end

      // Only currently free channels are offered for assignment
      assign channel_free[c] = !owner_valid[c];

      // Owned channels follow their owner, free ones sit idle
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          channel_out[c] <= `EPO_IDLE_LEVEL;
        else if (owner_valid[c])
          channel_out[c] <= slot_drive[owner_slot[c]];
        else
          channel_out[c] <= `EPO_IDLE_LEVEL;
      end
    end
  endgenerate

endmodule : epo_router

// >>> verification/epo_chk_sva.sv
`timescale 1ns/100ps
// Watches the router's pins only
module epo_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Controls
  input wire logic factory_calibration_integrator_keep,
  input wire epo_pkg::epo_cfg_s [2:0] user_cfg,
  input wire logic [2:0] user_present,
  input wire logic [2:0] user_level_in,
  input wire logic [15:0] status_pin,
  // Results
  input wire logic [8:0] channel_out,
  input wire logic [8:0] channel_free,
  input wire logic [3:0] slot_granted,
  input wire logic [3:0] state_change_event,
  input wire logic [15:0] status_in
);
  import epo_pkg::*;
  // User slots that claim nothing
  wire [2:0] idle_u = ~user_present | {user_cfg[2].port_sel == 4'h0,
    user_cfg[1].port_sel == 4'h0, user_cfg[0].port_sel == 4'h0};
  // Logging enables per user slot
  wire [2:0] lg = {user_cfg[2].state_change_logging_select,
    user_cfg[1].state_change_logging_select, user_cfg[0].state_change_logging_select};
  // Slot one in plain level mode
  wire lvl1 = user_cfg[0].kind == EPO_KIND_LEVEL && user_cfg[0].width_ms == 32'h0;
  // Cycles of calm on slot one; tolerant of the pipeline depth
  logic [2:0] calm;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      calm <= 3'h0;
    else if ($changed(user_cfg[0]) || $changed(user_level_in[0]) || !slot_granted[1])
      calm <= 3'h0;
    else if (calm != 3'h7)
      calm <= calm + 3'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_status; $past(reset_n, 2) |-> status_in == $past(status_pin, 2); endproperty
  a_status: assert property (p_status) else $error("status input delay wrong");
  property p_idle;
    (channel_free & $past(channel_free) & $past(channel_free, 2) & channel_out) == 9'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("free channel not idle");
  // Ownership settles one edge after a selection change, so only settled cycles count
  property p_owners;
    $stable(user_cfg) && $stable(user_present) && $stable(factory_calibration_integrator_keep)
      |-> $countones(~channel_free) == $countones(slot_granted);
  endproperty
  a_owners: assert property (p_owners) else $error("owner count mismatch");
  property p_fac_own; slot_granted[0] |-> !channel_free[6]; endproperty
  a_fac_own: assert property (p_fac_own) else $error("factory slot not on channel 7");
  property p_fac_rel; !factory_calibration_integrator_keep [*2] |-> !slot_granted[0]; endproperty
  a_fac_rel: assert property (p_fac_rel) else $error("removed factory slot kept");
  property p_usr_rel; (idle_u & $past(idle_u) & slot_granted[3:1]) == 3'h0; endproperty
  a_usr_rel: assert property (p_usr_rel) else $error("idle slot still granted");
  property p_grant;
    slot_granted[1] && !$past(idle_u[0]) |->
      !channel_free[$past(user_cfg[0].port_sel) - 4'h1];
  endproperty
  a_grant: assert property (p_grant) else $error("granted channel shows free");
  property p_level;
    calm == 3'h7 && $stable(user_level_in[0]) && $stable(user_cfg[0]) && lvl1 |->
      channel_out[user_cfg[0].port_sel - 4'h1] == (user_level_in[0] ^ user_cfg[0].invert);
  endproperty
  a_level: assert property (p_level) else $error("level output wrong");
  property p_event; (state_change_event[3:1] & ~lg) == 3'h0; endproperty
  a_event: assert property (p_event) else $error("event with logging off");
  c_grant: cover property (slot_granted[1]);
  c_event: cover property (state_change_event[1]);
  c_calib: cover property ($rose(channel_out[0]));
  c_pulser: cover property ($rose(channel_out[3]));
endmodule : epo_chk

// >>> verification/epo_counter.sv
`timescale 1ns/100ps
// Far-side pulse counter on every output channel
module epo_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Channels from the meter
  input wire logic [8:0] channel_out,
  // Pulses counted per channel
  output int rises [9]
);
  logic [8:0] last; // Previous channel levels
  // An idle-to-active step counts as one pulse
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      last <= 9'h0;
      rises <= '{default: 0};
    end
    else
    begin
      last <= channel_out;
      for (int i = 0; i < 9; i++)
        if (channel_out[i] && !last[i])
          rises[i] <= rises[i] + 1;
    end
endmodule : epo_counter

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import epo_pkg::*;
  // Stimulus
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic keep = 1'b1;
  logic [31:0] rs = 32'h9af39b7a;
  epo_cfg_s [2:0] ucfg = '0;
  logic [2:0] upres = 3'h0;
  logic [2:0] ulvl = 3'h0;
  logic [2:0] utrig = 3'h0;
  logic signed [2:0][31:0] upow = '0;
  logic [2:0] upv = 3'h0;
  logic [15:0] spin = 16'h0;
  logic signed [31:0] fpow = '0;
  logic fpv = 1'b0;
  // Observed
  logic [8:0] chan;
  logic [8:0] free;
  logic [3:0] gr;
  logic [3:0] ev_p;
  logic [15:0] sin;
  int rises [9];
  int num_errors = 0;
  int samples_checked = 0;
  int ev = 0;
  epo_router #(.TICK_CYCLES(20)) DUT (.clk(clk), .reset_n(reset_n),
    .factory_calibration_integrator_keep(keep), .total_real_power_source(fpow),
    .total_real_power_valid(fpv), .user_cfg(ucfg), .user_present(upres),
    .user_level_in(ulvl), .user_trigger(utrig), .user_power(upow), .user_power_valid(upv),
    .status_pin(spin), .channel_out(chan), .channel_free(free), .slot_granted(gr),
    .state_change_event(ev_p), .status_in(sin));
  epo_counter u_far (.clk(clk), .reset_n(reset_n), .channel_out(chan), .rises(rises));
  always #25 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Fresh random word every falling edge; it also feeds the status pins
  always @(negedge clk)
  begin
    rs = lfsr(rs);
    spin <= rs[15:0];
  end
  // Logged state changes of slot one
  always @(posedge clk)
    if (ev_p[1] === 1'b1)
      ev++;
  function automatic epo_cfg_s mk(logic [3:0] sel, epo_kind_e k, logic inv, logic lgs,
    epo_wave_e w, epo_int_e m, logic [31:0] wd);
    return '{sel, k, inv, lgs, w, m, wd, 40'h64};
  endfunction : mk
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic trig;
    utrig[2] = 1'b1;
    cyc(1);
    utrig[2] = 1'b0;
  endtask : trig
  task automatic cmp(string what, int exp, int got);
    samples_checked++;
    if (exp != got)
    begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp
  task automatic cmpv(string what, logic [8:0] exp, logic [8:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmpv
  task automatic finish_test;
    $display("Checked %0d values, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // Hang guard, about 2.4 times the expected run of some 17000 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    finish_test;
  end
  initial
  begin
    int b;
    int acc;
    int ex;
    int s;
    int c;
    cyc(5);
    cmpv("free", 9'h1ff, free);
    cmpv("out", 9'h0, chan);
    cyc(5);
    reset_n = 1'b1;
    cyc(3);
    cmpv("granted", 9'h1, {5'h0, gr});
    cmpv("free", 9'h1bf, free);
    // Contest for channel seven, then hand it over
    ucfg[0] = mk(4'h7, EPO_KIND_LEVEL, 1'b0, 1'b1, EPO_WAVE_FULL, EPO_INT_ABSOLUTE, 32'h0);
    upres = 3'h1;
    cyc(3);
    cmpv("granted", 9'h1, {5'h0, gr});
    keep = 1'b0;
    cyc(3);
    cmpv("granted", 9'h2, {5'h0, gr});
    keep = 1'b1;
    cyc(3);
    cmpv("granted", 9'h2, {5'h0, gr});
    ucfg[0].port_sel = 4'h9;
    cyc(4);
    cmpv("granted", 9'h3, {5'h0, gr});
    cmpv("free", 9'h0bf, free);
    $display("Ownership test done");
    // Inverted level on the alarm LED, with logging
    ucfg[0].invert = 1'b1;
    cyc(8);
    ev = 0;
    ex = 0;
    repeat (8)
    begin
      ex += (rs[3] != ulvl[0]);
      ulvl[0] = rs[3];
      cyc(8);
      cmpv("alarm", {8'h0, ~ulvl[0]}, {8'h0, chan[8]});
    end
    cmp("events", ex, ev);
    ulvl[0] = 1'b0;
    ucfg[0].width_ms = 32'h2;
    cyc(8);
    ulvl[0] = 1'b1;
    cyc(10);
    cmpv("level pulse", 9'h0, {8'h0, chan[8]});
    cyc(60);
    cmpv("level pulse", 9'h1, {8'h0, chan[8]});
    $display("Level test done");
    // Factory integrator on channel seven: absolute power, quantum 180, 50 ms pulse
    b = rises[6];
    acc = 0;
    ex = 0;
    repeat (6)
    begin
      s = int'(rs % 32'h12d) - 32'sh96;
      fpow = s;
      fpv = 1'b1;
      cyc(1);
      fpv = 1'b0;
      c = 0;
      acc += (s < 0) ? -s : s;
      if (acc >= 180)
      begin
        acc -= 180;
        ex++;
        c = 1;
      end
      cyc(500);
      cmpv("factory pulse", {8'h0, c[0]}, {8'h0, chan[6]});
      cyc(600);
      cmpv("factory idle", 9'h0, {8'h0, chan[6]});
    end
    cmp("factory pulses", ex, rises[6] - b);
    $display("Factory test done");
    // Integrator per direction; a level spell clears the accumulator
    for (int m = 0; m < 4; m++)
    begin
      ucfg[1] = mk(4'h1, EPO_KIND_LEVEL, 1'b0, 1'b0, EPO_WAVE_FULL, epo_int_e'(m), 32'ha);
      upres[1] = 1'b1;
      cyc(5);
      ucfg[1].kind = EPO_KIND_CALIB;
      cyc(5);
      b = rises[0];
      acc = 0;
      ex = 0;
      repeat (8)
      begin
        s = int'(rs % 32'hc7) - 32'sh63;
        upow[1] = s;
        upv[1] = 1'b1;
        cyc(1);
        upv[1] = 1'b0;
        c = (m == 3) ? s : (m == 2) ? (s < 0 ? -s : s) :
          (m == 1) ? (s < 0 ? -s : 0) : (s > 0 ? s : 0);
        acc += c;
        if (acc >= 100)
        begin
          acc -= 100;
          ex++;
        end
        cyc(300);
      end
      cmp("pulses", ex, rises[0] - b);
    end
    $display("Integrator test done");
    // Pulser: a trigger inside a pulse is dropped, then KYZ toggles
    ucfg[2] = mk(4'h4, EPO_KIND_PULSER, 1'b0, 1'b0, EPO_WAVE_FULL, EPO_INT_ABSOLUTE, 32'h14);
    upres[2] = 1'b1;
    cyc(5);
    b = rises[3];
    trig;
    cyc(5);
    trig;
    cyc(200);
    cmpv("pulser", 9'h1, {8'h0, chan[3]});
    cyc(250);
    cmpv("pulser", 9'h0, {8'h0, chan[3]});
    cmp("pulser count", 1, rises[3] - b);
    ucfg[2].output_waveform_select = EPO_WAVE_KYZ;
    cyc(5);
    for (int k = 1; k < 4; k++)
    begin
      trig;
      cyc(10);
      cmpv("kyz", {8'h0, k[0]}, {8'h0, chan[3]});
    end
    $display("Pulser test done");
    finish_test;
  end
endmodule : tb_top
bind epo_router epo_chk u_chk (.clk(clk), .reset_n(reset_n),
  .factory_calibration_integrator_keep(factory_calibration_integrator_keep),
  .user_cfg(user_cfg), .user_present(user_present), .user_level_in(user_level_in),
  .status_pin(status_pin), .channel_out(channel_out), .channel_free(channel_free),
  .slot_granted(slot_granted), .state_change_event(state_change_event),
  .status_in(status_in));
